// ### logic/tof_pkg.sv
// Constants and types for the timer overflow flag block
package tof_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] TOF_CTRL_ADDR = 8'hC8;
  localparam logic [7:0] TOF_CTRL_RESET = 8'h00;
  localparam logic [7:0] TOF_CTRL_WMASK = 8'hED;
  localparam int TOF_HI_FLAG_BIT = 7;
  localparam int TOF_LO_FLAG_BIT = 6;
  localparam int TOF_LO_IRQ_EN_BIT = 5;
  localparam int TOF_SPLIT_BIT = 3;
  localparam int TOF_RUN_BIT = 2;
  localparam int TOF_XCLK_BIT = 0;
  localparam logic [7:0] TOF_BYTE_MAX = 8'hFF;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic lower_inc;
    logic upper_inc;
    logic [7:0] timer_lower_byte;
    logic [7:0] timer_upper_byte;
  } tof_count_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_val;
  } tof_sfr_req_t;

endpackage : tof_pkg

// ### logic/tof_wrap_detect.sv
// Rollover detection for the two timer bytes
`timescale 1ns/10ps
`default_nettype none
module tof_wrap_detect
  import tof_pkg::*;
(
  input wire tof_count_t count_i,
  input wire logic split_mode_select_i,
  output logic low_wrap_o,
  output logic high_wrap_o
);

  logic lower_at_max;
  logic upper_at_max;

  assign lower_at_max = (count_i.timer_lower_byte == TOF_BYTE_MAX);
  assign upper_at_max = (count_i.timer_upper_byte == TOF_BYTE_MAX);

  // Lower byte wraps in either mode
  assign low_wrap_o = count_i.lower_inc && lower_at_max;

  // Split: upper byte counts alone; joined: carry out of full 16 bits
  always_comb begin
    if (split_mode_select_i) begin
      high_wrap_o = count_i.upper_inc && upper_at_max;
    end else begin
      high_wrap_o = count_i.lower_inc && lower_at_max && upper_at_max;
    end
  end

endmodule : tof_wrap_detect
`default_nettype wire

// ### logic/tof_flags.sv
// Timer overflow flags, control register and interrupt request
`timescale 1ns/10ps
`default_nettype none
module tof_flags
  import tof_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire tof_sfr_req_t sfr_req_i,
  input wire tof_count_t count_i,
  input wire logic timer_irq_en_i,
  output logic [7:0] sfr_rdata_o,
  output logic split_mode_select_o,
  output logic run_o,
  output logic ext_clk_sel_o,
  output logic irq_o
);

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic hits_bit(input tof_sfr_req_t req, input int idx);
    hits_bit = req.bit_wr && (req.addr == TOF_CTRL_ADDR + 8'(idx));
  endfunction : hits_bit

  logic [7:0] timer_control_reg;
  logic [7:0] next_ctrl;
  logic byte_wr;
  logic low_wrap;
  logic high_wrap;

  assign byte_wr = sfr_req_i.wr && (sfr_req_i.addr == TOF_CTRL_ADDR);

  tof_wrap_detect u_wrap (
    .count_i(count_i),
    .split_mode_select_i(timer_control_reg[TOF_SPLIT_BIT]),
    .low_wrap_o(low_wrap),
    .high_wrap_o(high_wrap)
  );

  // ****************************************
  // Software write value per bit
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      always_comb begin
        if (!TOF_CTRL_WMASK[gi]) begin
          next_ctrl[gi] = 1'b0;
        end else if (byte_wr) begin
          next_ctrl[gi] = sfr_req_i.wdata[gi];
        end else if (hits_bit(sfr_req_i, gi)) begin
          next_ctrl[gi] = sfr_req_i.bit_val;
        end else begin
          next_ctrl[gi] = timer_control_reg[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Control register; hardware set wins
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      timer_control_reg <= TOF_CTRL_RESET;
    end else begin
      timer_control_reg <= next_ctrl;
      if (high_wrap) begin
        timer_control_reg[TOF_HI_FLAG_BIT] <= 1'b1;
      end
      if (low_wrap) begin
        timer_control_reg[TOF_LO_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_req_i.rd && sfr_req_i.addr == TOF_CTRL_ADDR) begin
      sfr_rdata_o <= timer_control_reg & TOF_CTRL_WMASK;
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  // ****************************************
  // Control outputs and interrupt
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      split_mode_select_o <= 1'b0;
      run_o <= 1'b0;
      ext_clk_sel_o <= 1'b0;
    end else begin
      split_mode_select_o <= timer_control_reg[TOF_SPLIT_BIT];
      run_o <= timer_control_reg[TOF_RUN_BIT];
      ext_clk_sel_o <= timer_control_reg[TOF_XCLK_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= timer_irq_en_i && (timer_control_reg[TOF_HI_FLAG_BIT] ||
        (timer_control_reg[TOF_LO_IRQ_EN_BIT] && timer_control_reg[TOF_LO_FLAG_BIT]));
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_high_wrap_sets: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    high_wrap |=> timer_control_reg[TOF_HI_FLAG_BIT])
    else $error("high flag not set after upper wrap");

  a_joined_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!timer_control_reg[TOF_SPLIT_BIT] && count_i.lower_inc
     && {count_i.timer_upper_byte, count_i.timer_lower_byte} == 16'hFFFF)
    |=> timer_control_reg[TOF_HI_FLAG_BIT])
    else $error("high flag not set on 16-bit wrap");

  a_irq_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (timer_irq_en_i && timer_control_reg[TOF_HI_FLAG_BIT]) |=> irq_o)
    else $error("no interrupt for high flag");

  a_high_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (timer_control_reg[TOF_HI_FLAG_BIT] && !byte_wr && !hits_bit(sfr_req_i, TOF_HI_FLAG_BIT))
    |=> timer_control_reg[TOF_HI_FLAG_BIT])
    else $error("high flag cleared without write");

  a_low_wrap_sets: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (count_i.lower_inc && count_i.timer_lower_byte == 8'hFF)
    |=> timer_control_reg[TOF_LO_FLAG_BIT])
    else $error("low flag not set after lower wrap");

  a_low_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (timer_control_reg[TOF_LO_FLAG_BIT] && !byte_wr && !hits_bit(sfr_req_i, TOF_LO_FLAG_BIT))
    |=> timer_control_reg[TOF_LO_FLAG_BIT])
    else $error("low flag cleared without write");

  a_irq_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (timer_irq_en_i && timer_control_reg[TOF_LO_IRQ_EN_BIT]
     && timer_control_reg[TOF_LO_FLAG_BIT]) |=> irq_o)
    else $error("no interrupt for low flag");

  a_split_upper: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (timer_control_reg[TOF_SPLIT_BIT] && !count_i.upper_inc && !byte_wr
     && !hits_bit(sfr_req_i, TOF_HI_FLAG_BIT) && !timer_control_reg[TOF_HI_FLAG_BIT])
    |=> !timer_control_reg[TOF_HI_FLAG_BIT])
    else $error("split upper flag set without upper step");

  a_unused_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (sfr_req_i.rd && sfr_req_i.addr == TOF_CTRL_ADDR)
    |=> (sfr_rdata_o & ~TOF_CTRL_WMASK) == 8'h00)
    else $error("unused bit read nonzero");

  a_split_high_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (timer_control_reg[TOF_SPLIT_BIT] && count_i.upper_inc
     && count_i.timer_upper_byte == TOF_BYTE_MAX) |=> timer_control_reg[TOF_HI_FLAG_BIT])
    else $error("high flag not set on split upper wrap");

  a_high_set_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (high_wrap && (byte_wr || hits_bit(sfr_req_i, TOF_HI_FLAG_BIT)))
    |=> timer_control_reg[TOF_HI_FLAG_BIT])
    else $error("software clear beat high flag set");

  a_low_split_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (timer_control_reg[TOF_SPLIT_BIT] && count_i.lower_inc
     && count_i.timer_lower_byte == TOF_BYTE_MAX) |=> timer_control_reg[TOF_LO_FLAG_BIT])
    else $error("low flag not set in split mode");

  a_low_bit_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (hits_bit(sfr_req_i, TOF_LO_FLAG_BIT) && !byte_wr && !sfr_req_i.bit_val && !low_wrap)
    |=> !timer_control_reg[TOF_LO_FLAG_BIT])
    else $error("low flag not cleared by bit write");

  a_irq_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(timer_irq_en_i && (timer_control_reg[TOF_HI_FLAG_BIT]
     || (timer_control_reg[TOF_LO_IRQ_EN_BIT] && timer_control_reg[TOF_LO_FLAG_BIT])))
    |=> !irq_o)
    else $error("interrupt without pending flag");

  a_low_irq_gated: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!timer_control_reg[TOF_HI_FLAG_BIT] && !timer_control_reg[TOF_LO_IRQ_EN_BIT])
    |=> !irq_o)
    else $error("low flag interrupted while its enable is clear");

  a_joined_upper_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!timer_control_reg[TOF_SPLIT_BIT] && count_i.timer_upper_byte != TOF_BYTE_MAX
     && !byte_wr && !hits_bit(sfr_req_i, TOF_HI_FLAG_BIT)
     && !timer_control_reg[TOF_HI_FLAG_BIT]) |=> !timer_control_reg[TOF_HI_FLAG_BIT])
    else $error("joined high flag set without full wrap");

  a_split_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    1'b1 |=> split_mode_select_o == $past(timer_control_reg[TOF_SPLIT_BIT]))
    else $error("split select output wrong");

  // ****************************************
  // Assertions: control outputs and register access
  // ****************************************
  a_ctrl_outs: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    1'b1 |=> (run_o == $past(timer_control_reg[TOF_RUN_BIT])
     && ext_clk_sel_o == $past(timer_control_reg[TOF_XCLK_BIT])))
    else $error("run or clock select output wrong");

  a_read_data: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (sfr_req_i.rd && sfr_req_i.addr == TOF_CTRL_ADDR)
    |=> sfr_rdata_o == ($past(timer_control_reg) & TOF_CTRL_WMASK))
    else $error("read data does not match register");

  a_read_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(sfr_req_i.rd && sfr_req_i.addr == TOF_CTRL_ADDR) |=> sfr_rdata_o == 8'h00)
    else $error("read data not zero without read");

  a_unused_held: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (timer_control_reg & ~TOF_CTRL_WMASK) == 8'h00)
    else $error("unused control bit set");

  a_byte_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (byte_wr && !high_wrap && !low_wrap)
    |=> timer_control_reg == ($past(sfr_req_i.wdata) & TOF_CTRL_WMASK))
    else $error("byte write did not land");

endmodule : tof_flags
`default_nettype wire

// ### verification/tof_cnt_model.sv
// Timer byte counter model feeding the overflow flag block
`timescale 1ns/10ps
`default_nettype none
module tof_cnt_model
  import tof_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic load_i,
  input wire logic [15:0] load_val_i,
  input wire logic split_i,
  input wire logic run_i,
  input wire logic step_i,
  output var tof_count_t count_o
);
  logic [7:0] lo_q = 8'h00;
  logic [7:0] hi_q = 8'h00;
  logic lo_inc;
  logic hi_inc;
  assign lo_inc = step_i & (split_i | run_i);
  assign hi_inc = split_i ? (step_i & run_i) : (lo_inc & (lo_q == TOF_BYTE_MAX));
  assign count_o = {lo_inc, hi_inc, lo_q, hi_q};
  always @(posedge sys_clk_i) begin
    lo_q <= load_i ? load_val_i[7:0] : lo_q + 8'(lo_inc);
    hi_q <= load_i ? load_val_i[15:8] : hi_q + 8'(hi_inc);
  end
endmodule : tof_cnt_model
`default_nettype wire

// ### verification/tof_flags_tb.sv
// Self-checking bench for the timer overflow flag block
`timescale 1ns/10ps
`default_nettype none
module tof_flags_tb
  import tof_pkg::*;
;
  logic sys_clk_i = 0;
  logic rst_i = 1;
  logic en = 0;
  logic load = 0;
  logic step = 0;
  logic [15:0] lv = 0;
  tof_sfr_req_t req = '0;
  tof_count_t cnt;
  logic [7:0] rdata;
  logic [7:0] ctrl = 0;
  logic spl, run, xclk, irq;
  logic exp_irq = 0;
  int n_mismatch = 0;
  int compares = 0;
  initial forever #5 sys_clk_i = ~sys_clk_i;
  tof_cnt_model i_cnt (.sys_clk_i, .load_i(load), .load_val_i(lv), .split_i(spl),
    .run_i(run), .step_i(step), .count_o(cnt));
  tof_flags i_dut (.sys_clk_i, .rst_i, .sfr_req_i(req), .count_i(cnt), .timer_irq_en_i(en),
    .sfr_rdata_o(rdata), .split_mode_select_o(spl), .run_o(run), .ext_clk_sel_o(xclk),
    .irq_o(irq));
  function automatic logic hi_set(tof_count_t c, logic s);
    if (s) return c.upper_inc && c.timer_upper_byte == TOF_BYTE_MAX;
    return c.lower_inc && c.timer_lower_byte == TOF_BYTE_MAX && c.timer_upper_byte == 8'hFF;
  endfunction : hi_set
  // ****************************************
  // Expected register and interrupt
  // ****************************************
  always @(posedge sys_clk_i) begin : shadow
    logic [7:0] nx;
    nx = ctrl;
    if (req.bit_wr && req.addr[7:3] == TOF_CTRL_ADDR[7:3]) nx[req.addr[2:0]] = req.bit_val;
    if (req.wr && req.addr == TOF_CTRL_ADDR) nx = req.wdata;
    nx = nx & TOF_CTRL_WMASK;
    nx[7] = nx[7] | hi_set(cnt, ctrl[3]);
    nx[6] = nx[6] | (cnt.lower_inc && cnt.timer_lower_byte == TOF_BYTE_MAX);
    exp_irq <= !rst_i & en & (ctrl[7] | (ctrl[5] & ctrl[6]));
    ctrl <= rst_i ? TOF_CTRL_RESET : nx;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  always @(negedge sys_clk_i) if (!rst_i) check({7'h0, irq}, {7'h0, exp_irq});
  task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
    req = '{wr: !b, rd: 1'b0, bit_wr: b, addr: a, wdata: d, bit_val: d[0]};
    @(posedge sys_clk_i);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    req = '{wr: 1'b0, rd: 1'b1, bit_wr: 1'b0, addr: a, wdata: 8'h00, bit_val: 1'b0};
    @(posedge sys_clk_i);
    #1;
    v = rdata;
  endtask : rd
  task automatic idle(input int n);
    req = '0;
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : idle
  task automatic end_sim();
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial begin : main
    logic [7:0] v;
    void'($urandom(32'hbc3a));
    repeat (10) @(posedge sys_clk_i);
    #1 rst_i = 0;
    idle(1);
    rd(TOF_CTRL_ADDR, v);
    check(v, TOF_CTRL_RESET);
    wr(0, TOF_CTRL_ADDR, 8'hFF);
    rd(TOF_CTRL_ADDR, v);
    check(v, 8'hED);
    wr(0, 8'hC9, 8'h00);
    rd(8'hC9, v);
    check(v, 8'h00);
    rd(TOF_CTRL_ADDR, v);
    check(v, 8'hED);
    for (int i = 0; i < 40; i++) begin
      wr(0, TOF_CTRL_ADDR, 8'($urandom) & 8'hED);
      en = 1'($urandom);
      lv = (i % 4 == 0) ? 16'hFFFF : 16'hFF00 | 16'($urandom_range(255, 0));
      load = 1;
      idle(1);
      load = 0;
      idle(2);
      repeat (300) begin
        step = 1'($urandom);
        @(posedge sys_clk_i);
        #1;
      end
      step = 0;
      idle(3);
      rd(TOF_CTRL_ADDR, v);
      check(v, ctrl);
      check({5'h0, spl, run, xclk}, {5'h0, ctrl[3], ctrl[2], ctrl[0]});
      if (v[7]) wr(1, TOF_CTRL_ADDR + 8'h07, 8'h00);
      if (v[6]) wr(1, TOF_CTRL_ADDR + 8'h06, 8'h00);
      rd(TOF_CTRL_ADDR, v);
      check(v & 8'hC0, 8'h00);
    end
    // Corner: rollover and software clear of its flag in one cycle, set wins
    for (int k = 0; k < 2; k++) begin
      wr(0, TOF_CTRL_ADDR, k ? 8'h8C : 8'h48);
      lv = k ? 16'hFF00 : 16'h00FF;
      load = 1;
      idle(1);
      load = 0;
      step = 1;
      wr(1, TOF_CTRL_ADDR + (k ? 8'h07 : 8'h06), 8'h00);
      step = 0;
      rd(TOF_CTRL_ADDR, v);
      check(v, k ? 8'h8C : 8'h48);
      check(v, ctrl);
    end
    // Corner: bit writes to unused positions, read data idles at zero
    wr(1, TOF_CTRL_ADDR + 8'h04, 8'h01);
    wr(1, TOF_CTRL_ADDR + 8'h01, 8'h01);
    rd(TOF_CTRL_ADDR, v);
    check(v & 8'h12, 8'h00);
    idle(1);
    check(rdata, 8'h00);
    // Reset in mid-run: register and outputs return to zero
    rst_i = 1;
    idle(2);
    rst_i = 0;
    idle(1);
    rd(TOF_CTRL_ADDR, v);
    check(v, TOF_CTRL_RESET);
    check({5'h0, spl, run, xclk}, 8'h00);
    idle(2);
    end_sim();
  end
  initial begin : watchdog
    #400000;
    n_mismatch++;
    end_sim();
  end
endmodule : tof_flags_tb
`default_nettype wire
